// ---- include/erc_pkg.sv ----
// How it works
// - first write of standalone or load-share enable locks the configuration type.
// - the lock survives soft reset; only loss of supply releases it.
// - standalone locks with load-share zero; regulator still switches on and off.
// - standalone: change attempts are ignored, command-fault flag stays clear.
// - standalone: shunt threshold limits current and sets overcurrent flag only.
// - overcurrent flag holds until host clears it; clear works once condition gone.
// - standalone: undervoltage monitored and reported in the undervoltage flag.
// - load-share locks on first load-share write; standalone enable then has no function.
// - load-share locked: change attempts set command-fault flag, configuration unchanged.
// - keep bit clear: sharing off in stop mode, resumes in normal mode.
// - keep bit set: sharing stays enabled during stop mode.
// - sharing active in normal mode whenever load-share configuration is locked, except on low supply without keep-on bit.
// - load-share mode never reports third regulator undervoltage.
// - third regulator shuts down whenever the device is in fail-safe mode.
// - load-share mode has no current limiting; overcurrent flag never set.
// - regulator off on low supply, back on after recovery, unless keep-on bit set.
// - standalone: voltage select zero gives 5.0V, one gives 3.3V; ignored in load share.
package erc_pkg;

  // device operating modes
  typedef enum logic [2:0] {
    ERC_MODE_INIT,
    ERC_MODE_NORMAL,
    ERC_MODE_STOP,
    ERC_MODE_SLEEP,
    ERC_MODE_RESTART,
    ERC_MODE_FAILSAFE
  } erc_mode_t;

  // locked configuration type
  typedef enum logic [1:0] {
    ERC_CFG_NONE,
    ERC_CFG_STANDALONE,
    ERC_CFG_SHARE
  } erc_cfg_t;

  // one host write of the control bits
  typedef struct packed {
    logic standalone_enable;
    logic load_share_enable;
    logic share_in_stop_keep;
    logic keep_on_at_low_input;
    logic third_reg_voltage_select;
  } erc_ctrl_t;

  // analog monitor levels
  typedef struct packed {
    logic shunt_at_threshold;
    logic output_undervoltage;
    logic supply_undervoltage;
  } erc_mon_t;

  // drive to the analog regulator
  typedef struct packed {
    logic reg_on;
    logic share_on;
    logic current_limit_on;
    logic uv_monitor_on;
    logic select_3v3;
  } erc_drive_t;

  localparam erc_ctrl_t CTRL_RESET = 5'h00;
  localparam logic      SEL_5V0    = 1'h0;  // voltage select value for 5.0V

endpackage

// ---- hw/erc_sticky_flag.sv ----
`timescale 1ns/10ps
// sticky status flag: set wins over clear, clear blocked while cause persists
module erc_sticky_flag
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic set_i,
  input  wire logic cause_i,
  input  wire logic clear_i,
  output logic      flag_o
);

  logic flag_q;
  logic flag_d;

  // set has priority; a clear succeeds only once the cause is gone
  assign flag_d = set_i | (flag_q & ~(clear_i & ~cause_i));
  assign flag_o = flag_q;

  // register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      flag_q <= 1'h0;
    else
      flag_q <= flag_d;
  end

endmodule

// ---- hw/erc_third_regulator_ctrl.sv ----
`timescale 1ns/10ps
// control of the external-transistor third regulator with write-once configuration
module erc_third_regulator_ctrl
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic                 por,
  input  wire erc_pkg::erc_mode_t   mode,
  input  wire logic                 ctrl_wr,
  input  wire erc_pkg::erc_ctrl_t   ctrl_wdata,
  input  wire erc_pkg::erc_mon_t    mon,
  input  wire logic                 oc_clear,
  input  wire logic                 uv_clear,
  output erc_pkg::erc_cfg_t         cfg_locked,
  output erc_pkg::erc_ctrl_t        ctrl_rdata,
  output logic                      third_reg_overcurrent_flag,
  output logic                      third_reg_undervoltage_flag,
  output logic                      command_fault_pulse,
  output erc_pkg::erc_drive_t       drive
);

  ////////////////////////////////////////////////////////////////////////
  // configuration lock, held through soft reset

  erc_pkg::erc_cfg_t cfg_q;
  erc_pkg::erc_cfg_t cfg_d;
  wire               first_sa;
  wire               first_ls;
  wire               ls_change;

  // first enable bit written picks the type; load share wins if both
  assign first_ls  = ctrl_wr & (cfg_q == erc_pkg::ERC_CFG_NONE)
                     & ctrl_wdata.load_share_enable;
  assign first_sa  = ctrl_wr & (cfg_q == erc_pkg::ERC_CFG_NONE)
                     & ctrl_wdata.standalone_enable
                     & ~ctrl_wdata.load_share_enable;
  // under load share, clearing load share or setting standalone is a change
  assign ls_change = ctrl_wr & (cfg_q == erc_pkg::ERC_CFG_SHARE)
                     & (~ctrl_wdata.load_share_enable
                        | ctrl_wdata.standalone_enable);

  always_comb
  begin
    cfg_d = cfg_q;
    if (first_ls)
      cfg_d = erc_pkg::ERC_CFG_SHARE;
    else if (first_sa)
      cfg_d = erc_pkg::ERC_CFG_STANDALONE;
  end

  // only power-on reset clears the lock
  always_ff @(posedge sys_clk)
  begin
    if (por)
      cfg_q <= erc_pkg::ERC_CFG_NONE;
    else
      cfg_q <= cfg_d;
  end

  assign cfg_locked = cfg_q;

  ////////////////////////////////////////////////////////////////////////
  // control bits, all cleared by soft reset; the share bit follows the lock again next cycle

  erc_pkg::erc_ctrl_t ctrl_q;
  erc_pkg::erc_ctrl_t ctrl_d;
  wire                in_sa;
  wire                in_ls;

  assign in_sa = (cfg_d == erc_pkg::ERC_CFG_STANDALONE);
  assign in_ls = (cfg_d == erc_pkg::ERC_CFG_SHARE);

  always_comb
  begin
    ctrl_d = ctrl_q;
    if (ctrl_wr)
    begin
      ctrl_d.share_in_stop_keep       = ctrl_wdata.share_in_stop_keep;
      ctrl_d.keep_on_at_low_input     = ctrl_wdata.keep_on_at_low_input;
      ctrl_d.third_reg_voltage_select = ctrl_wdata.third_reg_voltage_select;
      // standalone may still switch on and off; a load-share request is dropped
      ctrl_d.standalone_enable = in_sa & ctrl_wdata.standalone_enable;
    end
    ctrl_d.load_share_enable = in_ls;
    if (in_ls)
      ctrl_d.standalone_enable = 1'h0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst | por)
    begin
      ctrl_q                   <= erc_pkg::CTRL_RESET;
      ctrl_q.load_share_enable <= 1'h0;
    end
    else
      ctrl_q <= ctrl_d;
  end

  assign ctrl_rdata = ctrl_q;

  ////////////////////////////////////////////////////////////////////////
  // command fault: pulse on a refused change under load share only

  logic fault_q;

  always_ff @(posedge sys_clk)
  begin
    if (rst | por)
      fault_q <= 1'h0;
    else
      fault_q <= ls_change;
  end

  assign command_fault_pulse = fault_q;

  ////////////////////////////////////////////////////////////////////////
  // regulator enable and drive

  wire sa_mode;
  wire ls_mode;
  wire fail_safe;
  wire low_supply_off;
  wire sa_allowed;
  wire ls_allowed;

  assign sa_mode        = (cfg_q == erc_pkg::ERC_CFG_STANDALONE);
  assign ls_mode        = (cfg_q == erc_pkg::ERC_CFG_SHARE);
  assign fail_safe      = (mode == erc_pkg::ERC_MODE_FAILSAFE);
  assign low_supply_off = mon.supply_undervoltage
                          & ~ctrl_q.keep_on_at_low_input;
  // standalone holds its state in all modes but init and fail-safe
  assign sa_allowed     = sa_mode & ctrl_q.standalone_enable
                          & (mode != erc_pkg::ERC_MODE_INIT);
  // sharing in normal and restart, in stop only when kept
  assign ls_allowed     = ls_mode
                          & ((mode == erc_pkg::ERC_MODE_NORMAL)
                             | (mode == erc_pkg::ERC_MODE_RESTART)
                             | ((mode == erc_pkg::ERC_MODE_STOP)
                                & ctrl_q.share_in_stop_keep));

  erc_pkg::erc_drive_t drive_d;
  erc_pkg::erc_drive_t drive_q;

  always_comb
  begin
    drive_d                  = '0;
    drive_d.reg_on           = (sa_allowed | ls_allowed)
                               & ~fail_safe & ~low_supply_off;
    drive_d.share_on         = drive_d.reg_on & ls_mode;
    drive_d.current_limit_on = drive_d.reg_on & sa_mode;
    drive_d.uv_monitor_on    = drive_d.reg_on & sa_mode;
    drive_d.select_3v3       = sa_mode
                               & (ctrl_q.third_reg_voltage_select != erc_pkg::SEL_5V0);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst | por)
      drive_q <= '0;
    else
      drive_q <= drive_d;
  end

  assign drive = drive_q;

  ////////////////////////////////////////////////////////////////////////
  // status flags

  wire oc_set;
  wire uv_set;

  assign oc_set = drive_q.current_limit_on & mon.shunt_at_threshold;
  assign uv_set = drive_q.uv_monitor_on & mon.output_undervoltage;

  erc_sticky_flag u_oc_flag
  (
    .sys_clk (sys_clk),
    .rst     (rst | por),
    .set_i   (oc_set),
    .cause_i (mon.shunt_at_threshold),
    .clear_i (oc_clear),
    .flag_o  (third_reg_overcurrent_flag)
  );

  erc_sticky_flag u_uv_flag
  (
    .sys_clk (sys_clk),
    .rst     (rst | por),
    .set_i   (uv_set),
    .cause_i (uv_set),
    .clear_i (uv_clear),
    .flag_o  (third_reg_undervoltage_flag)
  );

endmodule

// ---- sim/erc_chk.sv ----
`timescale 1ns/10ps
// port checks of the third regulator control
module erc_chk
(
  input wire logic                sys_clk,
  input wire logic                rst,
  input wire logic                por,
  input wire erc_pkg::erc_mode_t  mode,
  input wire logic                ctrl_wr,
  input wire erc_pkg::erc_ctrl_t  ctrl_wdata,
  input wire erc_pkg::erc_mon_t   mon,
  input wire logic                oc_clear,
  input wire erc_pkg::erc_cfg_t   cfg_locked,
  input wire erc_pkg::erc_ctrl_t  ctrl_rdata,
  input wire logic                third_reg_overcurrent_flag,
  input wire logic                third_reg_undervoltage_flag,
  input wire logic                command_fault_pulse,
  input wire erc_pkg::erc_drive_t drive
);
  // decoded lock state and refused write
  wire none_w = cfg_locked == erc_pkg::ERC_CFG_NONE;
  wire sh_w   = cfg_locked == erc_pkg::ERC_CFG_SHARE;
  wire oc_w   = third_reg_overcurrent_flag;
  wire bad_w  = ctrl_wr && (!ctrl_wdata.load_share_enable || ctrl_wdata.standalone_enable);
  wire stp_w  = sh_w && mode == erc_pkg::ERC_MODE_STOP;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst || por);
  lock_hold_a: assert property (disable iff (por) !none_w |=> $stable(cfg_locked))
    else $error("lock changed");
  share_lock_a: assert property (none_w && ctrl_wr && ctrl_wdata.load_share_enable |=> sh_w)
    else $error("share not locked");
  sa_lock_a: assert property (none_w && ctrl_wr && ctrl_wdata == 5'h10 |=> !none_w && !sh_w)
    else $error("standalone not locked");
  share_fault_a: assert property (sh_w && bad_w |=> command_fault_pulse && sh_w)
    else $error("no fault pulse");
  sa_quiet_a: assert property (!sh_w |=> !command_fault_pulse)
    else $error("fault outside share");
  share_flags_a: assert property (sh_w |-> !oc_w && !third_reg_undervoltage_flag)
    else $error("flag in share");
  failsafe_off_a: assert property (mode == erc_pkg::ERC_MODE_FAILSAFE |=> drive[4:3] == 2'h0)
    else $error("on in fail-safe");
  share_on_a: assert property (sh_w && mode == erc_pkg::ERC_MODE_NORMAL
    && (!mon.supply_undervoltage || ctrl_rdata.keep_on_at_low_input) |=> drive.share_on)
    else $error("share off in normal");
  stop_off_a: assert property (stp_w && !ctrl_rdata.share_in_stop_keep |=> !drive.share_on)
    else $error("share on in stop");
  oc_hold_a: assert property (oc_w && (!oc_clear || mon.shunt_at_threshold) |=> oc_w)
    else $error("overcurrent flag lost");
  // main scenarios
  cover property (none_w ##1 sh_w);
  cover property (command_fault_pulse);
  cover property (oc_w && oc_clear && !mon.shunt_at_threshold);
endmodule
bind erc_third_regulator_ctrl erc_chk u_chk (.sys_clk, .rst, .por, .mode, .ctrl_wr, .ctrl_wdata,
  .mon, .oc_clear, .cfg_locked, .ctrl_rdata, .third_reg_overcurrent_flag,
  .third_reg_undervoltage_flag, .command_fault_pulse, .drive);

// ---- sim/erc_host_model.sv ----
`timescale 1ns/10ps
// host: one write strobe per request, data scrambled while idle
module erc_host_model
(
  input  wire logic               sys_clk,
  input  wire logic               go,
  input  wire erc_pkg::erc_ctrl_t go_data,
  output erc_pkg::erc_ctrl_t      ctrl_wdata,
  output logic                    ctrl_wr
);
  // configuration goes first after power-up, unused enables left clear
  initial ctrl_wr = 1'h0;
  initial ctrl_wdata = 5'h00;
  always @(posedge sys_clk)
  begin
    ctrl_wr    <= go;
    ctrl_wdata <= go ? go_data : ~ctrl_wdata;
  end
endmodule

// ---- sim/erc_third_regulator_ctrl_tb.sv ----
`timescale 1ns/10ps
module erc_third_regulator_ctrl_tb;
  logic                sys_clk, rst, por, oc_clear, go, ctrl_wr, oc_f, uv_f, fault;
  erc_pkg::erc_mode_t  mode;
  erc_pkg::erc_ctrl_t  go_data, ctrl_wdata, ctrl_rdata;
  erc_pkg::erc_mon_t   mon;
  erc_pkg::erc_cfg_t   cfg_locked;
  erc_pkg::erc_drive_t drive;
  int                  failures, num_checks, seed, k;
  logic                vs, uv_clear;
  erc_third_regulator_ctrl dut (.sys_clk, .rst, .por, .mode, .ctrl_wr, .ctrl_wdata, .mon,
    .oc_clear, .uv_clear, .cfg_locked, .ctrl_rdata, .third_reg_overcurrent_flag(oc_f),
    .third_reg_undervoltage_flag(uv_f), .command_fault_pulse(fault), .drive);
  erc_host_model host (.sys_clk, .go, .go_data, .ctrl_wdata, .ctrl_wr);
  // compare, write, wait
  task automatic chk(string n, logic [4:0] e, logic [4:0] g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(erc_pkg::erc_ctrl_t d);
    @(posedge sys_clk);
    go <= 1'h1;
    go_data <= d;
    @(posedge sys_clk);
    go <= 1'h0;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic complete_run();
    if (failures == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  //////////////////////////////////////////////////
  // clock and watchdog
  initial
  begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    complete_run();
  end
  // share lock, then standalone lock after power-on reset
  initial
  begin
    seed = 10296;
    {rst, por, go, oc_clear} = 4'hF;
    go = 1'h0;
    oc_clear = 1'h0;
    uv_clear = 1'h0;
    go_data = 5'h00;
    mode = erc_pkg::ERC_MODE_INIT;
    mon = 3'h0;
    repeat (8) @(posedge sys_clk);
    {por, rst} <= 2'h0;
    wr(5'h08);
    chk("cfg", erc_pkg::ERC_CFG_SHARE, cfg_locked);
    mode <= erc_pkg::ERC_MODE_NORMAL;
    mon <= 3'($random(seed)) & 3'h6;
    cyc(3);
    chk("share_on", 5'h01, drive.share_on);
    chk("flags", 5'h00, {oc_f, uv_f});
    for (k = 0; k < 3; k++)
    begin
      wr(k == 0 ? 5'h00 : (k == 1 ? 5'h18 : 5'h10));
      chk("fault", 5'h01, fault);
      chk("cfg", erc_pkg::ERC_CFG_SHARE, cfg_locked);
    end
    for (k = 0; k < 2; k++)
    begin
      wr(k ? 5'h0C : 5'h08);
      mode <= erc_pkg::ERC_MODE_STOP;
      cyc(2);
      chk("stop", 5'(k), drive.share_on);
      mode <= erc_pkg::ERC_MODE_NORMAL;
      cyc(2);
      chk("resume", 5'h01, drive.share_on);
    end
    rst <= 1'h1;
    cyc(1);
    rst <= 1'h0;
    cyc(1);
    chk("cfg", erc_pkg::ERC_CFG_SHARE, cfg_locked);
    mode <= erc_pkg::ERC_MODE_FAILSAFE;
    cyc(2);
    chk("failsafe", 5'h00, drive[4:3]);
    por <= 1'h1;
    mode <= erc_pkg::ERC_MODE_NORMAL;
    mon <= 3'h0;
    cyc(1);
    por <= 1'h0;
    vs = 1'($random(seed));
    wr({4'h8, vs});
    chk("cfg", erc_pkg::ERC_CFG_STANDALONE, cfg_locked);
    wr({4'h4, vs});
    chk("fault", 5'h00, fault);
    chk("cfg", erc_pkg::ERC_CFG_STANDALONE, cfg_locked);
    wr({4'h8, vs});
    cyc(1);
    chk("on_sel", {4'h1, vs}, {drive.reg_on, drive.select_3v3});
    mon <= 3'h4;
    cyc(3);
    chk("oc", 5'h01, oc_f);
    for (k = 0; k < 2; k++)
    begin
      oc_clear <= 1'h1;
      cyc(1);
      oc_clear <= 1'h0;
      mon <= 3'h0;
      cyc(1);
      chk("oc_clr", 5'(1 - k), oc_f);
    end
    mon <= 3'h2;
    cyc(3);
    chk("uv", 5'h01, uv_f);
    mon <= 3'h1;
    cyc(2);
    chk("low_in", 5'h00, drive.reg_on);
    wr({4'h9, vs});
    cyc(1);
    chk("keep_on", 5'h01, drive.reg_on);
    uv_clear <= 1'h1;
    cyc(1);
    uv_clear <= 1'h0;
    cyc(1);
    chk("uv_clr", 5'h00, uv_f);
    complete_run();
  end
endmodule
